/* File: rtl/mswb_pkg.sv */
// Shared constants and types of the block-mode multi-sector write block.
// Assumes a single clock domain; imported by the address unit and the top.
`default_nettype none
package mswb_pkg;
  // Register port addresses
  localparam logic [3:0] REG_DATA = 4'h0;
  localparam logic [3:0] REG_FEAT = 4'h1;
  localparam logic [3:0] REG_SCNT = 4'h2;
  localparam logic [3:0] REG_SNUM = 4'h3;
  localparam logic [3:0] REG_CLO = 4'h4;
  localparam logic [3:0] REG_CHI = 4'h5;
  localparam logic [3:0] REG_DEVH = 4'h6;
  localparam logic [3:0] REG_CMD = 4'h7;
  localparam logic [3:0] REG_DCTL = 4'h8;
  localparam logic [3:0] REG_MULT = 4'h9;
  localparam logic [3:0] REG_ISTAT = 4'hA;
  localparam logic [3:0] REG_IMASK = 4'hB;
  // Task file slots inside the current/previous byte arrays
  localparam int TF_SCNT = 0;
  localparam int TF_SNUM = 1;
  localparam int TF_CLO = 2;
  localparam int TF_CHI = 3;
  // Opcodes
  localparam logic [7:0] OPC_W28 = 8'hC5;
  localparam logic [7:0] OPC_W48 = 8'h39;
  // Field positions
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_UNC = 6;
  localparam int ER_ABT = 2;
  localparam int DH_LBA = 6;
  localparam int DC_HOB = 7;
  localparam int IRQ_BLK = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_ERR = 2;
  localparam int IRQ_W = 3;
  // Counts and reset values
  localparam logic [7:0] WORD_LAST = 8'hFF;
  localparam logic [16:0] CNT28_ZERO = 17'h0_0100;
  localparam logic [16:0] CNT48_ZERO = 17'h1_0000;
  localparam logic [16:0] CNT_ONE = 17'h0_0001;
  localparam logic [7:0] DEVH_RST = 8'hA0;
  localparam logic [7:0] MULT_RST = 8'h00;
  typedef enum logic [1:0] {S_IDLE, S_DRQ, S_WAIT} mswb_state_type;
endpackage
`default_nettype wire

/* File: rtl/mswb_addr_if.sv */
// Carries load/step requests and the running sector address.
// Assumes the top drives ctrl and the address unit drives unit.
`default_nettype none
interface mswb_addr_if;
  logic load;
  logic step;
  logic lba_mode;
  logic ext;
  logic [47:0] ld_addr;
  logic [47:0] cur_addr;
  modport ctrl (output load, step, lba_mode, ext, ld_addr, input cur_addr);
  modport unit (input load, step, lba_mode, ext, ld_addr, output cur_addr);
endinterface
`default_nettype wire

/* File: rtl/mswb_addr_unit.sv */
// Running sector address: linear or cylinder/head/sector stepping.
// Assumes CHS packing {cyl[27:12], head[11:8], sector[7:0]}.
`default_nettype none
module mswb_addr_unit
  import mswb_pkg::*;
#(
  parameter logic [4:0] NUM_HEADS = 5'h10,
  parameter logic [7:0] SECT_PER_TRACK = 8'h3F
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  mswb_addr_if.unit au
);
  logic [47:0] addr_r;
  logic [47:0] addr_nxt;

  if (NUM_HEADS == 5'h00 || NUM_HEADS > 5'h10 ||
      SECT_PER_TRACK == 8'h00) begin : g_chk
    $error("mswb_addr_unit: geometry out of range");
  end

  always_comb begin
    addr_nxt = addr_r;
    if (au.load) begin
      addr_nxt = au.ld_addr;
    end else if (au.step) begin
      if (au.ext) begin
        addr_nxt = addr_r + 48'h0000_0000_0001;
      end else if (au.lba_mode) begin
        addr_nxt = {20'h0_0000, 28'(addr_r[27:0] + 28'h000_0001)};
      end else if (addr_r[7:0] >= SECT_PER_TRACK) begin
        addr_nxt[7:0] = 8'h01;
        if ({1'b0, addr_r[11:8]} >= NUM_HEADS - 5'h01) begin
          addr_nxt[11:8] = 4'h0;
          addr_nxt[27:12] = addr_r[27:12] + 16'h0001;
        end else begin
          addr_nxt[11:8] = addr_r[11:8] + 4'h1;
        end
      end else begin
        addr_nxt[7:0] = addr_r[7:0] + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      addr_r <= 48'h0000_0000_0000;
    end else if (ce) begin
      addr_r <= addr_nxt;
    end
  end

  assign au.cur_addr = addr_r;
endmodule // mswb_addr_unit
`default_nettype wire

/* File: rtl/mswb_irq_bit.sv */
// One sticky interrupt status bit, cleared by a one written to it.
// Assumes set and clear are single-cycle pulses on ref_clk.
`default_nettype none
module mswb_irq_bit (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic set,
  input wire logic clr,
  output logic stat
);
  logic stat_nxt;

  // A set in the clearing cycle survives
  always_comb begin
    stat_nxt = set | (stat & ~clr);
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stat <= 1'b0;
    end else if (ce) begin
      stat <= stat_nxt;
    end
  end
endmodule // mswb_irq_bit
`default_nettype wire

/* File: rtl/mswb_top.sv */
// Device-side block-mode multi-sector write, 28-bit and 48-bit variants.
// Assumes a host on the register port and a media sink on ref_clk.
//
// Notes on behaviour
// - Accept sectors, send them to media, interrupt once per block.
// - Payload moves as 16-bit words, one word per data access.
// - 28-bit variant: sector count zero means 256 sectors.
// - Linear bit set builds 28-bit address from task registers.
// - 28-bit end: count register holds sectors not transferred.
// - 28-bit end: address registers hold last transferred sector.
// - 48-bit variant: combined count zero means 65,536 sectors.
// - 48-bit error: failing address readable low or high by select.
// - Opcode C5h starts the 28-bit block write.
// - Opcode 39h starts the 48-bit block write.
`default_nettype none
module mswb_top
  import mswb_pkg::*;
#(
  parameter logic [4:0] NUM_HEADS = 5'h10,
  parameter logic [7:0] SECT_PER_TRACK = 8'h3F
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic irq,
  output logic dev_busy,
  output logic dev_drq,
  output logic media_start,
  output logic media_lba_mode,
  output logic [47:0] media_addr,
  output logic media_word_valid,
  output logic [15:0] media_word,
  input wire logic media_ack,
  input wire logic media_fail
);
  mswb_addr_if au ();

  mswb_state_type state_r, state_nxt;
  logic [3:0][7:0] cur_r, cur_nxt;
  logic [3:0][7:0] prv_r, prv_nxt;
  logic [7:0] devh_r, devh_nxt;
  logic [7:0] mult_r, mult_nxt;
  logic [IRQ_W-1:0] imask_r, imask_nxt;
  logic hob_r, hob_nxt;
  logic bsy_r, bsy_nxt;
  logic drq_r, drq_nxt;
  logic err_r, err_nxt;
  logic unc_r, unc_nxt;
  logic abt_r, abt_nxt;
  logic ext_r, ext_nxt;
  logic lba_r, lba_nxt;
  logic [16:0] rem_r, rem_nxt;
  logic [7:0] wcnt_r, wcnt_nxt;
  logic [7:0] sent_r, sent_nxt;
  logic [7:0] ackd_r, ackd_nxt;
  logic [7:0] blen_r, blen_nxt;
  logic mstart_r, mstart_nxt;
  logic mlba_r, mlba_nxt;
  logic [47:0] maddr_r, maddr_nxt;
  logic mvalid_r, mvalid_nxt;
  logic [15:0] mword_r, mword_nxt;
  logic irq_r, irq_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] ist;
  logic [IRQ_W-1:0] iclr;
  logic [1:0] tf_idx;
  logic idle;
  logic opc_ok;
  logic new_ext;
  logic new_lba;
  logic [16:0] new_cnt;
  logic [16:0] rem_dec;
  logic [47:0] start_addr;
  logic [47:0] cur_addr;
  logic [7:0] stat_b;
  logic [7:0] err_b;

  assign idle = (state_r == S_IDLE);
  assign tf_idx = 2'(reg_addr - REG_SCNT);
  assign cur_addr = au.cur_addr;
  assign rem_dec = rem_r - CNT_ONE;
  assign opc_ok = (reg_wdata[7:0] == OPC_W28) ||
                  (reg_wdata[7:0] == OPC_W48);
  assign new_ext = (reg_wdata[7:0] == OPC_W48);
  assign new_lba = new_ext | devh_r[DH_LBA];

  // Count zero stands for the full range of each variant
  always_comb begin
    if (new_ext) begin
      new_cnt = {1'b0, prv_r[TF_SCNT], cur_r[TF_SCNT]};
      if (new_cnt == 17'h0_0000) begin
        new_cnt = CNT48_ZERO;
      end
    end else if (cur_r[TF_SCNT] == 8'h00) begin
      new_cnt = CNT28_ZERO;
    end else begin
      new_cnt = {9'h000, cur_r[TF_SCNT]};
    end
  end

  // First sector address from the task file
  always_comb begin
    if (new_ext) begin
      start_addr = {prv_r[TF_CHI], prv_r[TF_CLO], prv_r[TF_SNUM],
                    cur_r[TF_CHI], cur_r[TF_CLO], cur_r[TF_SNUM]};
    end else if (new_lba) begin
      start_addr = {20'h0_0000, devh_r[3:0], cur_r[TF_CHI],
                    cur_r[TF_CLO], cur_r[TF_SNUM]};
    end else begin
      start_addr = {20'h0_0000, cur_r[TF_CHI], cur_r[TF_CLO],
                    devh_r[3:0], cur_r[TF_SNUM]};
    end
  end

  // Command, data and media acknowledge handling
  always_comb begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    prv_nxt = prv_r;
    devh_nxt = devh_r;
    mult_nxt = mult_r;
    imask_nxt = imask_r;
    hob_nxt = hob_r;
    bsy_nxt = bsy_r;
    drq_nxt = drq_r;
    err_nxt = err_r;
    unc_nxt = unc_r;
    abt_nxt = abt_r;
    ext_nxt = ext_r;
    lba_nxt = lba_r;
    rem_nxt = rem_r;
    wcnt_nxt = wcnt_r;
    sent_nxt = sent_r;
    ackd_nxt = ackd_r;
    blen_nxt = blen_r;
    mstart_nxt = 1'b0;
    mlba_nxt = mlba_r;
    maddr_nxt = maddr_r;
    mvalid_nxt = 1'b0;
    mword_nxt = mword_r;
    irq_nxt = |(ist & imask_r);
    ev = '0;
    au.load = 1'b0;
    au.step = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        REG_SCNT, REG_SNUM, REG_CLO, REG_CHI: begin
          if (idle) begin
            prv_nxt[tf_idx] = cur_r[tf_idx];
            cur_nxt[tf_idx] = reg_wdata[7:0];
            hob_nxt = 1'b0;
          end
        end
        REG_DEVH: begin
          if (idle) begin
            devh_nxt = reg_wdata[7:0];
          end
        end
        REG_DCTL: hob_nxt = reg_wdata[DC_HOB];
        REG_MULT: begin
          if (idle) begin
            mult_nxt = reg_wdata[7:0];
          end
        end
        REG_IMASK: imask_nxt = reg_wdata[IRQ_W-1:0];
        REG_CMD: begin
          if (idle && opc_ok && mult_r != 8'h00) begin
            ext_nxt = new_ext;
            lba_nxt = new_lba;
            rem_nxt = new_cnt;
            blen_nxt = (new_cnt < {9'h000, mult_r}) ? new_cnt[7:0] : mult_r;
            au.load = 1'b1;
            mstart_nxt = 1'b1;
            mlba_nxt = new_lba;
            maddr_nxt = start_addr;
            state_nxt = S_DRQ;
            drq_nxt = 1'b1;
            bsy_nxt = 1'b0;
            err_nxt = 1'b0;
            unc_nxt = 1'b0;
            abt_nxt = 1'b0;
            wcnt_nxt = 8'h00;
            sent_nxt = 8'h00;
            ackd_nxt = 8'h00;
          end else if (idle) begin
            err_nxt = 1'b1;
            abt_nxt = 1'b1;
            unc_nxt = 1'b0;
            ev[IRQ_ERR] = 1'b1;
          end
        end
        REG_DATA: begin
          if (state_r == S_DRQ) begin
            mvalid_nxt = 1'b1;
            mword_nxt = reg_wdata;
            wcnt_nxt = wcnt_r + 8'h01;
            if (wcnt_r == WORD_LAST) begin
              sent_nxt = sent_r + 8'h01;
              if (sent_r + 8'h01 == blen_r) begin
                state_nxt = S_WAIT;
                drq_nxt = 1'b0;
                bsy_nxt = 1'b1;
              end
            end
          end
        end
        default: ;
      endcase
    end
    if (!idle && media_ack) begin
      if (!media_fail || ext_r) begin
        if (ext_r) begin
          cur_nxt[TF_SNUM] = cur_addr[7:0];
          cur_nxt[TF_CLO] = cur_addr[15:8];
          cur_nxt[TF_CHI] = cur_addr[23:16];
          prv_nxt[TF_SNUM] = cur_addr[31:24];
          prv_nxt[TF_CLO] = cur_addr[39:32];
          prv_nxt[TF_CHI] = cur_addr[47:40];
        end else if (lba_r) begin
          cur_nxt[TF_SNUM] = cur_addr[7:0];
          cur_nxt[TF_CLO] = cur_addr[15:8];
          cur_nxt[TF_CHI] = cur_addr[23:16];
          devh_nxt[3:0] = cur_addr[27:24];
        end else begin
          cur_nxt[TF_SNUM] = cur_addr[7:0];
          devh_nxt[3:0] = cur_addr[11:8];
          cur_nxt[TF_CLO] = cur_addr[19:12];
          cur_nxt[TF_CHI] = cur_addr[27:20];
        end
      end
      if (media_fail) begin
        cur_nxt[TF_SCNT] = rem_r[7:0];
        if (ext_r) begin
          prv_nxt[TF_SCNT] = rem_r[15:8];
        end
        err_nxt = 1'b1;
        unc_nxt = 1'b1;
        ev[IRQ_ERR] = 1'b1;
        state_nxt = S_IDLE;
        bsy_nxt = 1'b0;
        drq_nxt = 1'b0;
      end else begin
        au.step = 1'b1;
        rem_nxt = rem_dec;
        cur_nxt[TF_SCNT] = rem_dec[7:0];
        if (ext_r) begin
          prv_nxt[TF_SCNT] = rem_dec[15:8];
        end
        ackd_nxt = ackd_r + 8'h01;
        if (ackd_r + 8'h01 == blen_r) begin
          ackd_nxt = 8'h00;
          sent_nxt = 8'h00;
          bsy_nxt = 1'b0;
          if (rem_r == CNT_ONE) begin
            ev[IRQ_DONE] = 1'b1;
            state_nxt = S_IDLE;
          end else begin
            ev[IRQ_BLK] = 1'b1;
            state_nxt = S_DRQ;
            drq_nxt = 1'b1;
            blen_nxt = (rem_dec < {9'h000, mult_r}) ? rem_dec[7:0] : mult_r;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_r <= S_IDLE;
      cur_r <= '0;
      prv_r <= '0;
      devh_r <= DEVH_RST;
      mult_r <= MULT_RST;
      imask_r <= '0;
      hob_r <= 1'b0;
      bsy_r <= 1'b0;
      drq_r <= 1'b0;
      err_r <= 1'b0;
      unc_r <= 1'b0;
      abt_r <= 1'b0;
      ext_r <= 1'b0;
      lba_r <= 1'b0;
      rem_r <= 17'h0_0000;
      wcnt_r <= 8'h00;
      sent_r <= 8'h00;
      ackd_r <= 8'h00;
      blen_r <= 8'h00;
      mstart_r <= 1'b0;
      mlba_r <= 1'b0;
      maddr_r <= 48'h0000_0000_0000;
      mvalid_r <= 1'b0;
      mword_r <= 16'h0000;
      irq_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      prv_r <= prv_nxt;
      devh_r <= devh_nxt;
      mult_r <= mult_nxt;
      imask_r <= imask_nxt;
      hob_r <= hob_nxt;
      bsy_r <= bsy_nxt;
      drq_r <= drq_nxt;
      err_r <= err_nxt;
      unc_r <= unc_nxt;
      abt_r <= abt_nxt;
      ext_r <= ext_nxt;
      lba_r <= lba_nxt;
      rem_r <= rem_nxt;
      wcnt_r <= wcnt_nxt;
      sent_r <= sent_nxt;
      ackd_r <= ackd_nxt;
      blen_r <= blen_nxt;
      mstart_r <= mstart_nxt;
      mlba_r <= mlba_nxt;
      maddr_r <= maddr_nxt;
      mvalid_r <= mvalid_nxt;
      mword_r <= mword_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Register read path, data one cycle after the strobe
  always_comb begin
    stat_b = 8'h00;
    stat_b[ST_BSY] = bsy_r;
    stat_b[ST_RDY] = 1'b1;
    stat_b[ST_DSC] = 1'b1;
    stat_b[ST_DRQ] = drq_r;
    stat_b[ST_ERR] = err_r;
    err_b = 8'h00;
    err_b[ER_UNC] = unc_r;
    err_b[ER_ABT] = abt_r;
    rdata_nxt = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        REG_FEAT: rdata_nxt[7:0] = err_b;
        REG_SCNT, REG_SNUM, REG_CLO, REG_CHI: begin
          rdata_nxt[7:0] = hob_r ? prv_r[tf_idx] : cur_r[tf_idx];
        end
        REG_DEVH: rdata_nxt[7:0] = devh_r;
        REG_CMD: rdata_nxt[7:0] = stat_b;
        REG_DCTL: rdata_nxt[DC_HOB] = hob_r;
        REG_MULT: rdata_nxt[7:0] = mult_r;
        REG_ISTAT: rdata_nxt[IRQ_W-1:0] = ist;
        REG_IMASK: rdata_nxt[IRQ_W-1:0] = imask_r;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rdata_r <= 16'h0000;
    end else if (ce) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign iclr = (reg_wr && reg_addr == REG_ISTAT) ?
                reg_wdata[IRQ_W-1:0] : '0;

  for (genvar i = 0; i < IRQ_W; i++) begin : g_ist
    mswb_irq_bit u_bit (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .ce(ce),
      .set(ev[i]),
      .clr(iclr[i]),
      .stat(ist[i])
    );
  end

  assign au.lba_mode = lba_r;
  assign au.ext = ext_r;
  assign au.ld_addr = start_addr;

  mswb_addr_unit #(
    .NUM_HEADS(NUM_HEADS),
    .SECT_PER_TRACK(SECT_PER_TRACK)
  ) u_addr (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .ce(ce),
    .au(au)
  );

  assign reg_rdata = rdata_r;
  assign irq = irq_r;
  assign dev_busy = bsy_r;
  assign dev_drq = drq_r;
  assign media_start = mstart_r;
  assign media_lba_mode = mlba_r;
  assign media_addr = maddr_r;
  assign media_word_valid = mvalid_r;
  assign media_word = mword_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_go(logic [7:0] op);
    ce && reg_wr && reg_addr == REG_CMD && idle && mult_r != 8'h00 &&
    reg_wdata[7:0] == op;
  endsequence
  sequence s_ok_ack;
    ce && !idle && media_ack && !media_fail;
  endsequence

  property p_op28;
    s_go(OPC_W28) |=> state_r == S_DRQ && !ext_r && drq_r && media_start;
  endproperty
  a_op28: assert property (p_op28) else $error("C5h not started");
  property p_op48;
    s_go(OPC_W48) |=> state_r == S_DRQ && ext_r && lba_r && media_start;
  endproperty
  a_op48: assert property (p_op48) else $error("39h not started");
  property p_cnt28;
    s_go(OPC_W28) ##0 cur_r[TF_SCNT] == 8'h00 |=> rem_r == CNT28_ZERO;
  endproperty
  a_cnt28: assert property (p_cnt28) else $error("zero not 256");
  property p_cnt48;
    s_go(OPC_W48) ##0 (cur_r[TF_SCNT] == 8'h00 && prv_r[TF_SCNT] == 8'h00)
      |=> rem_r == CNT48_ZERO;
  endproperty
  a_cnt48: assert property (p_cnt48) else $error("bad 48 count");
  property p_lba28;
    s_go(OPC_W28) ##0 devh_r[DH_LBA] |=> media_addr[27:0] ==
      $past({devh_r[3:0], cur_r[TF_CHI], cur_r[TF_CLO], cur_r[TF_SNUM]});
  endproperty
  a_lba28: assert property (p_lba28) else $error("bad lba");
  property p_word;
    ce && state_r == S_DRQ && reg_wr && reg_addr == REG_DATA
      |=> media_word_valid && media_word == $past(reg_wdata);
  endproperty
  a_word: assert property (p_word) else $error("data word lost");
  property p_blk;
    s_ok_ack ##0 (ackd_r + 8'h01 == blen_r && rem_r > CNT_ONE)
      |=> ist[IRQ_BLK] && drq_r ##1 !ce || irq || !imask_r[IRQ_BLK];
  endproperty
  a_blk: assert property (p_blk) else $error("no blk irq");
  property p_rem;
    s_ok_ack ##0 (rem_r == CNT_ONE && !ext_r)
      |=> idle && cur_r[TF_SCNT] == 8'h00 && !err_r && ist[IRQ_DONE];
  endproperty
  a_rem: assert property (p_rem) else $error("count not zero");
  property p_last28;
    s_ok_ack ##0 (!ext_r && lba_r)
      |=> cur_r[TF_SNUM] == $past(cur_addr[7:0]) &&
          devh_r[3:0] == $past(cur_addr[27:24]);
  endproperty
  a_last28: assert property (p_last28) else $error("bad last");
  property p_fail48;
    ce && !idle && media_ack && media_fail && ext_r
      |=> err_r && prv_r[TF_SNUM] == $past(cur_addr[31:24]) &&
          prv_r[TF_CHI] == $past(cur_addr[47:40]);
  endproperty
  a_fail48: assert property (p_fail48) else $error("bad fail");
endmodule // mswb_top
`default_nettype wire

/* File: testbench/mswb_media_model.sv */
// Media sink model: takes payload words and commits them sector by sector.
// Assumes the block's media port on ref_clk; 256 words make one sector.
`default_nettype none
module mswb_media_model (
  input wire logic ref_clk,
  input wire logic media_start,
  input wire logic media_word_valid,
  input wire logic [15:0] media_word,
  output logic media_ack,
  output logic media_fail
);
  timeunit 1ns;
  timeprecision 1ns;
  int fail_at = -1;
  int delay = 0;
  int n_words = 0;
  logic [15:0] last_word = 16'h0000;
  int wcnt = 0;
  int pend = 0;
  int n_sect = 0;
  int wait_c = 0;
  // One ack per sector, never before its last word
  always @(posedge ref_clk) begin
    media_ack <= 1'b0;
    media_fail <= 1'b0;
    if (media_start) begin
      wcnt = 0;
      pend = 0;
      n_sect = 0;
      n_words = 0;
    end
    if (media_word_valid) begin
      n_words++;
      last_word = media_word;
      wcnt++;
      if (wcnt == 256) begin
        wcnt = 0;
        pend++;
      end
    end
    if (pend > 0 && wait_c >= delay) begin
      media_ack <= 1'b1;
      media_fail <= (n_sect == fail_at);
      pend--;
      n_sect++;
      wait_c = 0;
    end else if (pend > 0) begin
      wait_c++;
    end
  end
endmodule // mswb_media_model
`default_nettype wire

/* File: testbench/mswb_top_tb.sv */
// Self-checking bench of the block-mode multi-sector write block.
// Assumes the media model is compiled before this file.
`default_nettype none
module mswb_top_tb
  import mswb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, media_word, rv;
  logic irq, dev_busy, dev_drq, media_start, media_lba_mode;
  logic media_word_valid, media_ack, media_fail;
  logic [47:0] media_addr;
  logic [15:0] wseq = 16'h0000;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  localparam int CYC_MAX = 20000;

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  mswb_top uut (.ref_clk, .reset_n, .ce, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq, .dev_busy, .dev_drq, .media_start,
    .media_lba_mode, .media_addr, .media_word_valid, .media_word,
    .media_ack, .media_fail);
  mswb_media_model media (.ref_clk, .media_start, .media_word_valid,
    .media_word, .media_ack, .media_fail);

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [47:0] e,
                     input logic [47:0] g);
    total_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      n_fail++;
    end
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rc(input logic [3:0] a, input logic [7:0] e,
                    input string n);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    rv = reg_rdata;
    chk(n, {40'h0, e}, {40'h0, rv[7:0]});
  endtask

  // Waits for idle (drq_want 0) or a data request (drq_want 1)
  task automatic wait_st(input logic drq_want);
    int i;
    i = 0;
    @(negedge ref_clk);
    while ({dev_busy, dev_drq} !== {1'b0, drq_want} && i < 3000) begin
      @(negedge ref_clk);
      i++;
    end
    chk("state", {47'h0, drq_want}, {46'h0, dev_busy, dev_drq});
  endtask

  task automatic send_block(input int nsec);
    wait_st(1'b1);
    for (int i = 0; i < nsec * 256; i++) begin
      wseq = wseq + 16'h0001;
      wr(REG_DATA, wseq);
    end
    @(negedge ref_clk);
    chk("busy after block", 48'h2, {46'h0, dev_busy, dev_drq});
  endtask

  task automatic cmd(input logic [7:0] op);
    wr(REG_CMD, {8'h00, op});
    @(negedge ref_clk);
    chk("start", 48'h1, {47'h0, media_start});
  endtask

  task automatic t_reset();
    rc(REG_DEVH, 8'hA0, "devh reset");
    rc(REG_CMD, 8'h50, "status reset");
    rc(4'hC, 8'h00, "unmapped");
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(REG_MULT, 16'h0005);
    ce <= 1'b1;
    rc(REG_MULT, 8'h00, "frozen");
    $display("done reset");
  endtask

  task automatic t_abort();
    wr(REG_IMASK, 16'h0007);
    wr(REG_CMD, {8'h00, OPC_W28});
    rc(REG_FEAT, 8'h04, "abort error");
    rc(REG_CMD, 8'h51, "abort status");
    rc(REG_ISTAT, 8'h04, "abort istat");
    chk("abort irq", 48'h1, {47'h0, irq});
    wr(REG_ISTAT, 16'h0004);
    wr(REG_MULT, 16'h0001);
    wr(REG_CMD, 16'h0030);
    rc(REG_ISTAT, 8'h04, "other opcode");
    rc(REG_CMD, 8'h51, "not started");
    wr(REG_ISTAT, 16'h0004);
    $display("done abort");
  endtask

  task automatic t_w28();
    wr(REG_MULT, 16'h0002);
    wr(REG_SCNT, 16'h0003);
    wr(REG_SNUM, 16'h0012);
    wr(REG_CLO, 16'h0034);
    wr(REG_CHI, 16'h0056);
    wr(REG_DEVH, 16'h00E7);
    cmd(OPC_W28);
    chk("lba addr", 48'h0000_0756_3412, media_addr);
    chk("lba mode", 48'h1, {47'h0, media_lba_mode});
    send_block(2);
    wait_st(1'b1);
    rc(REG_ISTAT, 8'h01, "block irq");
    chk("irq", 48'h1, {47'h0, irq});
    wr(REG_ISTAT, 16'h0001);
    rc(REG_ISTAT, 8'h00, "irq cleared");
    chk("irq low", 48'h0, {47'h0, irq});
    send_block(1);
    wait_st(1'b0);
    rc(REG_ISTAT, 8'h02, "done irq");
    rc(REG_SCNT, 8'h00, "left 28");
    rc(REG_SNUM, 8'h14, "last snum");
    rc(REG_CLO, 8'h34, "last clo");
    rc(REG_CHI, 8'h56, "last chi");
    rc(REG_DEVH, 8'hE7, "last head");
    chk("words", 48'h300, 48'(media.n_words));
    chk("last word", {32'h0, wseq}, {32'h0, media.last_word});
    $display("done w28");
  endtask

  task automatic t_chs();
    wr(REG_MULT, 16'h0001);
    wr(REG_SCNT, 16'h0000);
    wr(REG_SNUM, 16'h0005);
    wr(REG_CLO, 16'h0010);
    wr(REG_CHI, 16'h0000);
    wr(REG_DEVH, 16'h00A2);
    cmd(OPC_W28);
    chk("chs addr", 48'h0000_0001_0205, media_addr);
    chk("chs mode", 48'h0, {47'h0, media_lba_mode});
    send_block(1);
    wait_st(1'b1);
    rc(REG_SCNT, 8'hFF, "left of 256");
    rc(REG_SNUM, 8'h05, "chs sector");
    do_reset();
    $display("done chs");
  endtask

  task automatic t_w48_fail();
    media.fail_at = 1;
    media.delay = 6;
    wr(REG_IMASK, 16'h0007);
    wr(REG_MULT, 16'h0004);
    wr(REG_SCNT, 16'h0000);
    wr(REG_SCNT, 16'h0002);
    wr(REG_SNUM, 16'h00AB);
    wr(REG_SNUM, 16'h0001);
    wr(REG_CLO, 16'h00CD);
    wr(REG_CLO, 16'h0002);
    wr(REG_CHI, 16'h00EF);
    wr(REG_CHI, 16'h0003);
    cmd(OPC_W48);
    chk("lba48", 48'hEFCD_AB03_0201, media_addr);
    send_block(2);
    wait_st(1'b0);
    rc(REG_FEAT, 8'h40, "unc");
    rc(REG_ISTAT, 8'h04, "err irq");
    rc(REG_SCNT, 8'h01, "left on fail");
    rc(REG_SNUM, 8'h02, "fail 7:0");
    rc(REG_CLO, 8'h02, "fail 15:8");
    rc(REG_CHI, 8'h03, "fail 23:16");
    wr(REG_DCTL, 16'h0080);
    rc(REG_SNUM, 8'hAB, "fail 31:24");
    rc(REG_CLO, 8'hCD, "fail 39:32");
    rc(REG_CHI, 8'hEF, "fail 47:40");
    media.fail_at = -1;
    media.delay = 0;
    do_reset();
    $display("done w48 fail");
  endtask

  task automatic t_w48_zero();
    wr(REG_MULT, 16'h0001);
    wr(REG_SCNT, 16'h0000);
    wr(REG_SCNT, 16'h0000);
    cmd(OPC_W48);
    send_block(1);
    wait_st(1'b1);
    rc(REG_SCNT, 8'hFF, "left low");
    wr(REG_DCTL, 16'h0080);
    rc(REG_SCNT, 8'hFF, "left high");
    do_reset();
    $display("done w48 zero");
  endtask

  initial begin
    do_reset();
    t_reset();
    t_abort();
    t_w28();
    t_chs();
    t_w48_fail();
    t_w48_zero();
    complete_run();
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == CYC_MAX) begin
      n_fail++;
      complete_run();
    end
  end
endmodule // mswb_top_tb
`default_nettype wire
